// [verilog/irq_instruction_exec.v]
// interrupt-group instruction execution with AXI4-Lite register access
//
// Summary of operation
// - mask instruction clears the interrupt enable flag.
// - unmask instruction sets the interrupt enable flag.
// - gate low: ext0 flag set means clear it and skip next.
// - gate high: ext0 skip test is a no-operation, flag untouched.
// - level select one: pin skip taken when pin reads high.
// - level select zero: pin skip taken when pin reads low.
// - read_irq_ctrl_a copies irq_ctrl_a into the accumulator.
// - write_irq_ctrl_a loads irq_ctrl_a from the accumulator.
// - read_irq_ctrl_b copies irq_ctrl_b into the accumulator.
// - write_irq_ctrl_b loads irq_ctrl_b from the accumulator.
// - read_ext_ctrl copies ext_ctrl into the accumulator.
// - write_ext_ctrl loads ext_ctrl from the accumulator.

`include "irq_exec_map.vh"

module irq_instruction_exec #(
    parameter ADDR_W = 8,
    parameter DATA_W = 4
) (
    input wire sys_clk,
    input wire srst,
    // instruction side
    input wire instValid,
    input wire [9:0] instWord,
    input wire [DATA_W-1:0] accIn,
    output reg accWrEn_q,
    output reg [DATA_W-1:0] accWrData_q,
    output reg skipNext_q,
    output reg instDone_q,
    // interrupt state
    input wire ext0Event,
    input wire extPin,
    output reg irqEnable_q,
    output reg ext0Flag_q,
    output reg irq_q,
    // axi4-lite slave
    input wire [ADDR_W-1:0] awaddr,
    input wire awvalid,
    output reg awready_q,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready_q,
    output reg [1:0] bresp_q,
    output reg bvalid_q,
    input wire bready,
    input wire [ADDR_W-1:0] araddr,
    input wire arvalid,
    output reg arready_q,
    output reg [31:0] rdata_q,
    output reg [1:0] rresp_q,
    output reg rvalid_q,
    input wire rready
);

    // ****************************************
    // declarations
    // ****************************************
    reg skipPend_q;
    reg [ADDR_W-1:0] awAddr_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;
    reg [`ST_WIDTH-1:0] intStatus_q;
    reg [`ST_WIDTH-1:0] intMask_q;
    wire [DATA_W-1:0] ctrlA;
    wire [DATA_W-1:0] ctrlB;
    wire [DATA_W-1:0] extCtrl;
    wire exec;
    wire isMask;
    wire isUnmask;
    wire isSkipExt0;
    wire isSkipPin;
    wire isRdA;
    wire isWrA;
    wire isRdB;
    wire isWrB;
    wire isRdExt;
    wire isWrExt;
    wire ext0Gate;
    wire levelSel;
    wire ext0Skip;
    wire pinSkip;
    wire skipTaken;
    wire wrFire;
    wire wrLow;
    wire busWrA;
    wire busWrB;
    wire busWrExt;
    wire busWrStatus;
    wire busWrMask;
    wire wrMapped;
    wire [`ST_WIDTH-1:0] stEvents;
    reg [31:0] rdData;
    reg rdMapped;

    // ****************************************
    // instruction decode
    // ****************************************
    // a fetched word right after a taken skip is dropped
    assign exec = instValid & ~skipPend_q;
    assign isMask = exec & (instWord == `OP_IRQ_MASK);
    assign isUnmask = exec & (instWord == `OP_IRQ_UNMASK);
    assign isSkipExt0 = exec & (instWord == `OP_SKIP_EXT0);
    assign isSkipPin = exec & (instWord == `OP_SKIP_PIN);
    assign isRdA = exec & (instWord == `OP_RD_CTRL_A);
    assign isWrA = exec & (instWord == `OP_WR_CTRL_A);
    assign isRdB = exec & (instWord == `OP_RD_CTRL_B);
    assign isWrB = exec & (instWord == `OP_WR_CTRL_B);
    assign isRdExt = exec & (instWord == `OP_RD_EXT_CTRL);
    assign isWrExt = exec & (instWord == `OP_WR_EXT_CTRL);

    // ****************************************
    // skip conditions
    // ****************************************
    assign ext0Gate = ctrlA[`EXT0_GATE_BIT];
    assign levelSel = extCtrl[`PIN_LEVEL_BIT];
    // gate high turns the test into a no-operation
    assign ext0Skip = isSkipExt0 & ~ext0Gate & ext0Flag_q;
    // level select picks which pin level skips
    assign pinSkip = isSkipPin & (levelSel ? extPin : ~extPin);
    assign skipTaken = ext0Skip | pinSkip;

    // ****************************************
    // skip sequencing and completion
    // ****************************************
    always @(posedge sys_clk) begin
        if (srst) begin
            skipPend_q <= 1'b0;
            skipNext_q <= 1'b0;
            instDone_q <= 1'b0;
        end else begin
            skipNext_q <= skipTaken;
            instDone_q <= exec;
            if (skipTaken) begin
                skipPend_q <= 1'b1;
            end else if (instValid) begin
                skipPend_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // interrupt enable flag
    // ****************************************
    always @(posedge sys_clk) begin
        if (srst) begin
            irqEnable_q <= 1'b0;
        end else if (isMask) begin
            irqEnable_q <= 1'b0;
        end else if (isUnmask) begin
            irqEnable_q <= 1'b1;
        end
    end

    // ****************************************
    // ext0 request flag
    // ****************************************
    // a new request in the clearing cycle is kept
    always @(posedge sys_clk) begin
        if (srst) begin
            ext0Flag_q <= 1'b0;
        end else if (ext0Event) begin
            ext0Flag_q <= 1'b1;
        end else if (ext0Skip) begin
            ext0Flag_q <= 1'b0;
        end
    end

    // ****************************************
    // accumulator transfers
    // ****************************************
    always @(posedge sys_clk) begin
        if (srst) begin
            accWrEn_q <= 1'b0;
            accWrData_q <= `CTRL_RESET;
        end else begin
            accWrEn_q <= isRdA | isRdB | isRdExt;
            if (isRdA) begin
                accWrData_q <= ctrlA;
            end else if (isRdB) begin
                accWrData_q <= ctrlB;
            end else if (isRdExt) begin
                accWrData_q <= extCtrl;
            end
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    ctrl_nibble #(
        .WIDTH(DATA_W)
    ) u_ctrlA (
        .sys_clk(sys_clk),
        .srst(srst),
        .instWe(isWrA),
        .instData(accIn),
        .busWe(busWrA),
        .busData(wData_q[DATA_W-1:0]),
        .value_q(ctrlA)
    );

    ctrl_nibble #(
        .WIDTH(DATA_W)
    ) u_ctrlB (
        .sys_clk(sys_clk),
        .srst(srst),
        .instWe(isWrB),
        .instData(accIn),
        .busWe(busWrB),
        .busData(wData_q[DATA_W-1:0]),
        .value_q(ctrlB)
    );

    ctrl_nibble #(
        .WIDTH(DATA_W)
    ) u_extCtrl (
        .sys_clk(sys_clk),
        .srst(srst),
        .instWe(isWrExt),
        .instData(accIn),
        .busWe(busWrExt),
        .busData(wData_q[DATA_W-1:0]),
        .value_q(extCtrl)
    );

    // ****************************************
    // bus write channel
    // ****************************************
    // both address and data held, response slot free
    assign wrFire = ~awready_q & ~wready_q & ~bvalid_q;
    assign wrLow = wrFire & wStrb_q[0];
    assign busWrA = wrLow & (awAddr_q == `REG_CTRL_A);
    assign busWrB = wrLow & (awAddr_q == `REG_CTRL_B);
    assign busWrExt = wrLow & (awAddr_q == `REG_EXT_CTRL);
    assign busWrStatus = wrLow & (awAddr_q == `REG_INT_STATUS);
    assign busWrMask = wrLow & (awAddr_q == `REG_INT_MASK);
    assign wrMapped = (awAddr_q == `REG_CTRL_A) | (awAddr_q == `REG_CTRL_B) |
        (awAddr_q == `REG_EXT_CTRL) | (awAddr_q == `REG_STATE) |
        (awAddr_q == `REG_INT_STATUS) | (awAddr_q == `REG_INT_MASK);

    always @(posedge sys_clk) begin
        if (srst) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
            awAddr_q <= {ADDR_W{1'b0}};
            wData_q <= 32'h0;
            wStrb_q <= 4'h0;
        end else begin
            if (awvalid & awready_q) begin
                awAddr_q <= awaddr;
                awready_q <= 1'b0;
            end
            if (wvalid & wready_q) begin
                wData_q <= wdata;
                wStrb_q <= wstrb;
                wready_q <= 1'b0;
            end
            if (wrFire) begin
                bvalid_q <= 1'b1;
                bresp_q <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bvalid_q & bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // ****************************************
    // interrupt status and mask
    // ****************************************
    assign stEvents = {skipTaken, ext0Event};

    // hardware set wins over write-one-to-clear
    always @(posedge sys_clk) begin
        if (srst) begin
            intStatus_q <= {`ST_WIDTH{1'b0}};
            intMask_q <= {`ST_WIDTH{1'b0}};
            irq_q <= 1'b0;
        end else begin
            if (busWrStatus) begin
                intStatus_q <= (intStatus_q & ~wData_q[`ST_WIDTH-1:0]) | stEvents;
            end else begin
                intStatus_q <= intStatus_q | stEvents;
            end
            if (busWrMask) begin
                intMask_q <= wData_q[`ST_WIDTH-1:0];
            end
            irq_q <= |(intStatus_q & intMask_q);
        end
    end

    // ****************************************
    // bus read channel
    // ****************************************
    always @* begin
        rdData = 32'h0;
        rdMapped = 1'b1;
        if (araddr == `REG_CTRL_A) begin
            rdData[DATA_W-1:0] = ctrlA;
        end else if (araddr == `REG_CTRL_B) begin
            rdData[DATA_W-1:0] = ctrlB;
        end else if (araddr == `REG_EXT_CTRL) begin
            rdData[DATA_W-1:0] = extCtrl;
        end else if (araddr == `REG_STATE) begin
            rdData[3:0] = {skipPend_q, extPin, ext0Flag_q, irqEnable_q};
        end else if (araddr == `REG_INT_STATUS) begin
            rdData[`ST_WIDTH-1:0] = intStatus_q;
        end else if (araddr == `REG_INT_MASK) begin
            rdData[`ST_WIDTH-1:0] = intMask_q;
        end else begin
            rdMapped = 1'b0;
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= `RESP_OKAY;
        end else begin
            if (arvalid & arready_q) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rdData;
                rresp_q <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (rvalid_q & rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

endmodule // irq_instruction_exec

// [verilog/irq_exec_map.vh]
// opcodes, register offsets, field positions and reset values
`ifndef IRQ_EXEC_MAP_VH
`define IRQ_EXEC_MAP_VH

// ****************************************
// instruction codes (10-bit words)
// ****************************************
`define OP_IRQ_MASK 10'h004
`define OP_IRQ_UNMASK 10'h005
`define OP_SKIP_EXT0 10'h038
`define OP_SKIP_PIN 10'h03a
`define OP_RD_CTRL_A 10'h054
`define OP_WR_CTRL_A 10'h03f
`define OP_RD_CTRL_B 10'h055
`define OP_WR_CTRL_B 10'h03e
`define OP_RD_EXT_CTRL 10'h253
`define OP_WR_EXT_CTRL 10'h217

// ****************************************
// control bit positions
// ****************************************
`define EXT0_GATE_BIT 0
`define PIN_LEVEL_BIT 2

// ****************************************
// register byte offsets
// ****************************************
`define REG_CTRL_A 8'h00
`define REG_CTRL_B 8'h04
`define REG_EXT_CTRL 8'h08
`define REG_STATE 8'h0c
`define REG_INT_STATUS 8'h10
`define REG_INT_MASK 8'h14

// ****************************************
// status bits and reset values
// ****************************************
`define ST_EXT0_EVENT 0
`define ST_SKIP_TAKEN 1
`define ST_WIDTH 2
`define CTRL_RESET 4'h0
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// [verilog/ctrl_nibble.v]
// one four-bit control register written by instruction or by bus
module ctrl_nibble #(
    parameter WIDTH = 4
) (
    input wire sys_clk,
    input wire srst,
    input wire instWe,
    input wire [WIDTH-1:0] instData,
    input wire busWe,
    input wire [WIDTH-1:0] busData,
    output reg [WIDTH-1:0] value_q
);

    // instruction write wins over bus write in the same cycle
    always @(posedge sys_clk) begin
        if (srst) begin
            value_q <= {WIDTH{1'b0}};
        end else if (instWe) begin
            value_q <= instData;
        end else if (busWe) begin
            value_q <= busData;
        end
    end

endmodule // ctrl_nibble

// [tb/irq_exec_checker.sv]
// assertion checker for the interrupt-group executor
`include "irq_exec_map.vh"
module irq_exec_checker (
    input logic sys_clk,
    input logic srst,
    input logic instValid,
    input logic [9:0] instWord,
    input logic accWrEn_q,
    input logic skipNext_q,
    input logic instDone_q,
    input logic irqEnable_q,
    input logic ext0Flag_q,
    input logic ext0Event
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // skip tracking
    // ****
    logic pend_q;
    logic ex;
    assign ex = instValid && !skipNext_q && !pend_q;
    always_ff @(posedge sys_clk) begin
        if (srst) pend_q <= 1'b0;
        else pend_q <= (skipNext_q || pend_q) && !instValid;
    end
    // ****
    // assertions
    // ****
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    a_mask_clear: assert property (
        ex && instWord == `OP_IRQ_MASK |=> !irqEnable_q) else $error("enable not cleared");
    a_unmask_set: assert property (
        ex && instWord == `OP_IRQ_UNMASK |=> irqEnable_q) else $error("enable not set");
    a_ext0_result: assert property (
        ex && instWord == `OP_SKIP_EXT0 && !ext0Event
        |=> (skipNext_q ? !ext0Flag_q : ext0Flag_q == $past(ext0Flag_q)))
        else $error("ext0 skip result wrong");
    a_ext0_noflag: assert property (
        ex && instWord == `OP_SKIP_EXT0 && !ext0Flag_q |=> !skipNext_q)
        else $error("skip without flag");
    a_skip_cause: assert property (
        skipNext_q |-> $past(ex) && $past(instWord) inside {`OP_SKIP_EXT0, `OP_SKIP_PIN})
        else $error("skip without skip op");
    a_drop_next: assert property (
        instValid && (skipNext_q || pend_q) |=> !instDone_q && !accWrEn_q)
        else $error("skipped word executed");
    a_done_pulse: assert property (
        ex |=> instDone_q ##1 (instDone_q == $past(ex))) else $error("done pulse wrong");
    a_read_pulse: assert property (
        ex && instWord inside {`OP_RD_CTRL_A, `OP_RD_CTRL_B, `OP_RD_EXT_CTRL} |=> accWrEn_q)
        else $error("no accumulator write");
endmodule // irq_exec_checker

bind irq_instruction_exec irq_exec_checker i_chk (.sys_clk, .srst, .instValid, .instWord,
    .accWrEn_q, .skipNext_q, .instDone_q, .irqEnable_q, .ext0Flag_q, .ext0Event);

// [tb/fetch_model.sv]
// accumulator model on the fetch side of the executor
module fetch_model (
    input logic sys_clk,
    input logic srst,
    input logic accWrEn_q,
    input logic [3:0] accWrData_q,
    input logic loadEn,
    input logic [3:0] loadVal,
    output logic [3:0] accIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] acc_q;
    assign accIn = acc_q;
    always_ff @(posedge sys_clk) begin
        if (srst) acc_q <= 4'h0;
        else if (accWrEn_q) acc_q <= accWrData_q;
        else if (loadEn) acc_q <= loadVal;
    end
endmodule // fetch_model

// [tb/irq_instruction_exec_tb.sv]
// self-checking bench for the interrupt-group executor
`include "irq_exec_map.vh"
module irq_instruction_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, srst, instValid, ext0Event, extPin, loadEn;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic accWrEn_q, skipNext_q, instDone_q, irqEnable_q, ext0Flag_q, irq_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic sk, d1, dn, en, fl, ae;
    logic [9:0] instWord;
    logic [3:0] accIn, loadVal, wstrb, accWrData_q;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata_q, rd;
    logic [1:0] bresp_q, rresp_q, rs;
    logic [9:0] wrOp [3] = '{`OP_WR_CTRL_A, `OP_WR_CTRL_B, `OP_WR_EXT_CTRL};
    logic [9:0] rdOp [3] = '{`OP_RD_CTRL_A, `OP_RD_CTRL_B, `OP_RD_EXT_CTRL};
    logic [3:0] vals [3] = '{4'ha, 4'h5, 4'hc};
    int n_errors = 0;
    int tests_run = 0;

    irq_instruction_exec i_dut (.sys_clk, .srst, .instValid, .instWord, .accIn, .accWrEn_q,
        .accWrData_q, .skipNext_q, .instDone_q, .ext0Event, .extPin, .irqEnable_q, .ext0Flag_q,
        .irq_q, .awaddr, .awvalid, .awready_q, .wdata, .wstrb, .wvalid, .wready_q, .bresp_q,
        .bvalid_q, .bready, .araddr, .arvalid, .arready_q, .rdata_q, .rresp_q, .rvalid_q, .rready);
    fetch_model i_fetch (.sys_clk, .srst, .accWrEn_q, .accWrData_q, .loadEn, .loadVal, .accIn);

    // ****
    // shared tasks
    // ****
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task busWr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready_q) awvalid <= 1'b0;
            if (wready_q) wvalid <= 1'b0;
        end while (!bvalid_q);
        rs = bresp_q;
        bready <= 1'b0;
    endtask
    task busRd(input logic [7:0] a);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready_q) arvalid <= 1'b0;
        end while (!rvalid_q);
        rd = rdata_q;
        rs = rresp_q;
        rready <= 1'b0;
    endtask
    task setAcc(input logic [3:0] v);
        @(posedge sys_clk);
        loadEn <= 1'b1;
        loadVal <= v;
        @(posedge sys_clk);
        loadEn <= 1'b0;
    endtask
    task pulseEv;
        @(posedge sys_clk);
        ext0Event <= 1'b1;
        @(posedge sys_clk);
        ext0Event <= 1'b0;
    endtask
    // two words back to back, outputs sampled after each
    task run2(input logic [9:0] a, input logic [9:0] b);
        @(posedge sys_clk);
        instValid <= 1'b1;
        instWord <= a;
        @(posedge sys_clk);
        instWord <= b;
        #1;
        sk = skipNext_q;
        fl = ext0Flag_q;
        ae = accWrEn_q;
        d1 = instDone_q;
        @(posedge sys_clk);
        instValid <= 1'b0;
        #1;
        dn = instDone_q;
        en = irqEnable_q;
    endtask

    // ****
    // scenarios
    // ****
    task t_reset;
        for (int i = 0; i < 6; i++) begin
            busRd(8'(i * 4));
            chk(rd, 32'h0);
            chk(rs, `RESP_OKAY);
        end
        busRd(8'h18);
        chk(rs, `RESP_SLVERR);
        chk(rd, 32'h0);
        busWr(8'h18, 32'h1);
        chk(rs, `RESP_SLVERR);
        $display("reset test done");
    endtask
    task t_enable;
        run2(`OP_IRQ_UNMASK, 10'h000);
        chk(en, 1'b1);
        chk(d1, 1'b1);
        run2(`OP_IRQ_MASK, 10'h000);
        chk(en, 1'b0);
        $display("enable test done");
    endtask
    task t_xfer;
        for (int k = 0; k < 3; k++) begin
            setAcc(vals[k]);
            run2(wrOp[k], 10'h000);
            busRd(8'(k * 4));
            chk(rd, {28'h0, vals[k]});
            setAcc(~vals[k]);
            run2(rdOp[k], 10'h000);
            chk(ae, 1'b1);
            chk(accIn, vals[k]);
        end
        $display("transfer test done");
    endtask
    task t_ext0;
        busWr(`REG_CTRL_A, 32'h0);
        pulseEv;
        run2(`OP_SKIP_EXT0, `OP_IRQ_UNMASK);
        chk({sk, fl}, 2'b10);
        chk({dn, en}, 2'b00);
        run2(`OP_SKIP_EXT0, `OP_IRQ_UNMASK);
        chk({sk, dn, en}, 3'b011);
        busWr(`REG_CTRL_A, 32'h1);
        pulseEv;
        run2(`OP_SKIP_EXT0, `OP_IRQ_MASK);
        chk({sk, fl, en}, 3'b010);
        $display("ext0 test done");
    endtask
    task t_pin;
        for (int lv = 0; lv < 2; lv++) begin
            for (int p = 0; p < 2; p++) begin
                busWr(`REG_EXT_CTRL, 32'(lv << 2));
                extPin <= 1'(p);
                run2(`OP_SKIP_PIN, 10'h000);
                chk(sk, p == lv);
                chk(dn, p != lv);
            end
        end
        $display("pin test done");
    endtask
    task t_irq;
        #1;
        chk(irq_q, 1'b0);
        busWr(`REG_INT_MASK, 32'h1);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(irq_q, 1'b1);
        busRd(`REG_INT_STATUS);
        chk(rd, 32'h3);
        busWr(`REG_INT_STATUS, 32'h3);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(irq_q, 1'b0);
        busRd(`REG_INT_STATUS);
        chk(rd, 32'h0);
        $display("interrupt test done");
    endtask

    // ****
    // clock, watchdog, main
    // ****
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (6000) @(posedge sys_clk);
        n_errors++;
        give_verdict;
    end
    initial begin
        {srst, instValid, ext0Event, extPin, loadEn} = 5'b10000;
        {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
        {instWord, loadVal, wstrb, awaddr, araddr, wdata} = '0;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset;
        t_enable;
        t_xfer;
        t_ext0;
        t_pin;
        t_irq;
        give_verdict;
    end
endmodule // irq_instruction_exec_tb
